// *** clock_range_consts.svh ***
// constants for the clock input mode and full-scale range registers
`ifndef CLOCK_RANGE_CONSTS_SVH
`define CLOCK_RANGE_CONSTS_SVH

// ----------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------
`define ADDR_DELAY_CTRL    15'h0029
`define ADDR_INPUT_MODE    15'h002a
`define ADDR_SUPPLY_NOISE  15'h002b
`define ADDR_EDGE_POS_B0   15'h002c
`define ADDR_EDGE_POS_B1   15'h002d
`define ADDR_EDGE_POS_B2   15'h002e
`define ADDR_FULL_SCALE_B0 15'h0030
`define ADDR_FULL_SCALE_B1 15'h0031

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define POS_SAMPLE_PECL    2
`define POS_REF_PECL       1
`define POS_REF_INVERT     0
`define POS_ANALOG_QUIET   2
`define POS_CLOCK_QUIET    0
`define POS_FINE_ZOOM      4
`define POS_DELAY_SEL_HI   3
`define POS_DELAY_SEL_LO   0

// ----------------------------------------------------------------------
// reset values
// ----------------------------------------------------------------------
`define RST_DELAY_CTRL     8'h80
`define RST_INPUT_MODE     8'h00
`define RST_SUPPLY_NOISE   8'h10
`define RST_EDGE_POS       24'h00_0000
`define RST_FULL_SCALE     16'ha000
`define RST_READ_DATA      8'h00

`endif

// *** clock_range_pkg.sv ***
// types shared by the clock input mode and full-scale range registers
package clock_range_pkg;
  typedef logic [14:0] reg_addr_t;
  typedef logic [7:0]  reg_byte_t;
  typedef logic [23:0] edge_pos_t;
  typedef logic [15:0] full_scale_t;
endpackage : clock_range_pkg

// *** three_stage_sync.sv ***
// three-stage synchroniser that accepts a bit once stages two and three agree
`timescale 1ns/10ps
module three_stage_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  input  wire logic [WIDTH-1:0] async_in,
  output logic      [WIDTH-1:0] stable_out
);

  // ----------------------------------------------------------------------
  // per-bit chain
  // ----------------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < WIDTH; g++)
    begin : g_bit
      logic stage1;
      logic stage2;
      logic stage3;
      // first stage feeds only the second; stable bit moves on agreement
      always_ff @(posedge core_clk or negedge arst_n)
      begin
        if (!arst_n)
        begin
          stage1        <= 1'b0;
          stage2        <= 1'b0;
          stage3        <= 1'b0;
          stable_out[g] <= 1'b0;
        end
        else
        begin
          stage1 <= async_in[g];
          stage2 <= stage1;
          stage3 <= stage2;
          if (stage2 == stage3)
            stable_out[g] <= stage3;
        end
      end
    end
  endgenerate

endmodule : three_stage_sync

// *** clock_input_and_range_regs.sv ***
// clock input mode, supply noise, edge position and full-scale registers
//
// What this block does
// - bit 2 puts sample clock in pecl mode
// - bit 1 puts alignment reference in pecl
// - bit 0 inverts the alignment reference
// - supply noise register resets 0x10, input 0x00
// - bit 2 enables analog supply noise suppression
// - bit 0 enables clock supply noise suppression
// - read-only 24-bit edge position, zero after reset
// - 16-bit full-scale range, resets 0xA000
// - delay select field at bits 3:0
// - zoom bit 4 passed out as alignment_fine_zoom; edge position reads not scaled
`timescale 1ns/10ps
`include "clock_range_consts.svh"
module clock_input_and_range_regs (
  input  wire logic                        core_clk,
  input  wire logic                        arst_n,
  input  wire logic                        wr_en,
  input  wire logic                        rd_en,
  input  wire clock_range_pkg::reg_addr_t  reg_addr,
  input  wire clock_range_pkg::reg_byte_t  wr_data,
  output clock_range_pkg::reg_byte_t       rd_data,
  output logic                             rd_valid,
  input  wire clock_range_pkg::edge_pos_t  edge_pos_raw,
  input  wire logic                        alignment_ref_raw,
  output logic                             alignment_ref_aligned,
  output logic                             sample_clock_pecl_mode,
  output logic                             alignment_ref_pecl_mode,
  output logic                             analog_supply_quiet_enable,
  output logic                             clock_supply_quiet_enable,
  output logic [3:0]                       alignment_delay_select,
  output logic                             alignment_fine_zoom,
  output clock_range_pkg::full_scale_t     full_scale_adjust
);

  // ----------------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------------
  clock_range_pkg::reg_byte_t   delay_ctrl;
  clock_range_pkg::reg_byte_t   input_clock_mode_control;
  clock_range_pkg::reg_byte_t   supply_noise_control;
  clock_range_pkg::edge_pos_t   alignment_edge_position;
  logic                         ref_sync;
  logic [24:0]                  sync_out;

  // address match, shared by the write and read decoders
  function automatic logic addr_hit(input clock_range_pkg::reg_addr_t a,
                                    input clock_range_pkg::reg_addr_t r);
    addr_hit = (a == r);
  endfunction : addr_hit

  // ----------------------------------------------------------------------
  // crossing of the edge position detector and the reference pin
  // ----------------------------------------------------------------------
  three_stage_sync #(.WIDTH(25)) u_sync (
    .core_clk   (core_clk),
    .arst_n     (arst_n),
    .async_in   ({alignment_ref_raw, edge_pos_raw}),
    .stable_out (sync_out)
  );
  assign alignment_edge_position = sync_out[23:0];
  assign ref_sync                = sync_out[24];

  // ----------------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------------
  wire hit_delay = addr_hit(reg_addr, `ADDR_DELAY_CTRL);
  wire hit_mode  = addr_hit(reg_addr, `ADDR_INPUT_MODE);
  wire hit_noise = addr_hit(reg_addr, `ADDR_SUPPLY_NOISE);
  wire hit_pos0  = addr_hit(reg_addr, `ADDR_EDGE_POS_B0);
  wire hit_pos1  = addr_hit(reg_addr, `ADDR_EDGE_POS_B1);
  wire hit_pos2  = addr_hit(reg_addr, `ADDR_EDGE_POS_B2);
  wire hit_fs0   = addr_hit(reg_addr, `ADDR_FULL_SCALE_B0);
  wire hit_fs1   = addr_hit(reg_addr, `ADDR_FULL_SCALE_B1);

  // write strobes; the edge position bytes have none so writes drop
  wire wr_delay = wr_en && hit_delay;
  wire wr_mode  = wr_en && hit_mode;
  wire wr_noise = wr_en && hit_noise;
  wire wr_fs0   = wr_en && hit_fs0;
  wire wr_fs1   = wr_en && hit_fs1;

  // read mux; unmapped addresses read zero, reads change nothing
  clock_range_pkg::reg_byte_t next_rd_data;
  assign next_rd_data =
    hit_delay ? delay_ctrl :
    hit_mode  ? input_clock_mode_control :
    hit_noise ? supply_noise_control :
    hit_pos0  ? alignment_edge_position[7:0] :
    hit_pos1  ? alignment_edge_position[15:8] :
    hit_pos2  ? alignment_edge_position[23:16] :
    hit_fs0   ? full_scale_adjust[7:0] :
    hit_fs1   ? full_scale_adjust[15:8] :
                `RST_READ_DATA;

  // ----------------------------------------------------------------------
  // control registers; reserved bits store what software writes
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      delay_ctrl               <= `RST_DELAY_CTRL;
      input_clock_mode_control <= `RST_INPUT_MODE;
      supply_noise_control     <= `RST_SUPPLY_NOISE;
    end
    else
    begin
      if (wr_delay)
        delay_ctrl <= wr_data;
      if (wr_mode)
        input_clock_mode_control <= wr_data;
      if (wr_noise)
        supply_noise_control <= wr_data;
    end
  end

  // full-scale range, low byte at the lower address
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      full_scale_adjust <= `RST_FULL_SCALE;
    else
    begin
      if (wr_fs0)
        full_scale_adjust[7:0] <= wr_data;
      if (wr_fs1)
        full_scale_adjust[15:8] <= wr_data;
    end
  end

  // ----------------------------------------------------------------------
  // registered outputs driving the analog controls
  // ----------------------------------------------------------------------
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      sample_clock_pecl_mode     <= 1'b0;
      alignment_ref_pecl_mode    <= 1'b0;
      analog_supply_quiet_enable <= 1'b0;
      clock_supply_quiet_enable  <= 1'b0;
      alignment_delay_select     <= 4'h0;
      alignment_fine_zoom        <= 1'b0;
      alignment_ref_aligned      <= 1'b0;
    end
    else
    begin
      sample_clock_pecl_mode     <=
        input_clock_mode_control[`POS_SAMPLE_PECL];
      alignment_ref_pecl_mode    <=
        input_clock_mode_control[`POS_REF_PECL];
      analog_supply_quiet_enable <=
        supply_noise_control[`POS_ANALOG_QUIET];
      clock_supply_quiet_enable  <=
        supply_noise_control[`POS_CLOCK_QUIET];
      alignment_delay_select     <=
        delay_ctrl[`POS_DELAY_SEL_HI:`POS_DELAY_SEL_LO];
      alignment_fine_zoom        <= delay_ctrl[`POS_FINE_ZOOM];
      alignment_ref_aligned      <=
        ref_sync ^ input_clock_mode_control[`POS_REF_INVERT];
    end
  end

  // read answer one cycle after the request
  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rd_data  <= `RST_READ_DATA;
      rd_valid <= 1'b0;
    end
    else
    begin
      rd_valid <= rd_en;
      if (rd_en)
        rd_data <= next_rd_data;
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!arst_n);

  property p_sample_pecl;
    wr_mode |-> ##2 sample_clock_pecl_mode == $past(wr_data[2], 2);
  endproperty
  a_sample_pecl: assert property (p_sample_pecl)
    else $error("sample clock pecl mode does not follow write");

  property p_ref_pecl;
    wr_mode |-> ##2 alignment_ref_pecl_mode == $past(wr_data[1], 2);
  endproperty
  a_ref_pecl: assert property (p_ref_pecl)
    else $error("reference pecl mode does not follow write");

  property p_invert;
    ##1 alignment_ref_aligned ==
      ($past(ref_sync) ^ $past(input_clock_mode_control[0]));
  endproperty
  a_invert: assert property (p_invert)
    else $error("reference polarity wrong");

  property p_quiet;
    wr_noise |-> ##2 (analog_supply_quiet_enable == $past(wr_data[2], 2))
      && (clock_supply_quiet_enable == $past(wr_data[0], 2));
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("quiet enables do not follow write");

  property p_pos_read;
    rd_en && hit_pos1 |=> rd_valid
      && rd_data == $past(alignment_edge_position[15:8]);
  endproperty
  a_pos_read: assert property (p_pos_read)
    else $error("edge position middle byte read wrong");

  property p_fs_write;
    wr_fs1 && !wr_fs0 |=> full_scale_adjust ==
      {$past(wr_data), $past(full_scale_adjust[7:0])};
  endproperty
  a_fs_write: assert property (p_fs_write)
    else $error("full-scale high byte write wrong");

  property p_delay_sel;
    wr_delay |-> ##2 alignment_delay_select == $past(wr_data[3:0], 2)
      && alignment_fine_zoom == $past(wr_data[4], 2);
  endproperty
  a_delay_sel: assert property (p_delay_sel)
    else $error("delay select or zoom does not follow write");

  property p_pos_no_write;
    wr_en && (hit_pos0 || hit_pos1 || hit_pos2) |=>
      $stable(full_scale_adjust) && $stable(input_clock_mode_control)
      && $stable(supply_noise_control) && $stable(delay_ctrl);
  endproperty
  a_pos_no_write: assert property (p_pos_no_write)
    else $error("write to edge position changed a register");

  // any address outside the map answers zero with the strobe
  property p_unmapped;
    rd_en && !(hit_delay || hit_mode || hit_noise || hit_pos0 || hit_pos1
      || hit_pos2 || hit_fs0 || hit_fs1) |=> rd_data == 8'h00 && rd_valid;
  endproperty
  a_unmapped: assert property (p_unmapped)
    else $error("unmapped read not zero");

  c_fs_write: cover property (wr_fs0 ##1 wr_fs1);
  c_pos_read: cover property (rd_en && hit_pos2 ##1 rd_valid);
  c_invert:   cover property (wr_mode && wr_data[0] ##2 alignment_ref_aligned);

endmodule : clock_input_and_range_regs

// *** testbench.sv ***
// self-checking bench for the clock input mode and full-scale registers
`timescale 1ns/10ps
`include "clock_range_consts.svh"
module testbench;
  logic                          core_clk;
  logic                          arst_n;
  logic                          wr_en;
  logic                          rd_en;
  clock_range_pkg::reg_addr_t    reg_addr;
  clock_range_pkg::reg_byte_t    wr_data;
  clock_range_pkg::reg_byte_t    rd_data;
  logic                          rd_valid;
  clock_range_pkg::edge_pos_t    edge_pos_raw;
  logic                          alignment_ref_raw;
  logic                          alignment_ref_aligned;
  logic                          sample_clock_pecl_mode;
  logic                          alignment_ref_pecl_mode;
  logic                          analog_supply_quiet_enable;
  logic                          clock_supply_quiet_enable;
  logic [3:0]                    alignment_delay_select;
  logic                          alignment_fine_zoom;
  clock_range_pkg::full_scale_t  full_scale_adjust;
  int                            errors;
  int                            n_compared;
  int                            cycles;
  int                            i;
  clock_range_pkg::full_scale_t  fs_codes [2];

  // ----------------------------------------------------------------------
  // design under test
  // ----------------------------------------------------------------------
  clock_input_and_range_regs dut_u (
    .core_clk                   (core_clk),
    .arst_n                     (arst_n),
    .wr_en                      (wr_en),
    .rd_en                      (rd_en),
    .reg_addr                   (reg_addr),
    .wr_data                    (wr_data),
    .rd_data                    (rd_data),
    .rd_valid                   (rd_valid),
    .edge_pos_raw               (edge_pos_raw),
    .alignment_ref_raw          (alignment_ref_raw),
    .alignment_ref_aligned      (alignment_ref_aligned),
    .sample_clock_pecl_mode     (sample_clock_pecl_mode),
    .alignment_ref_pecl_mode    (alignment_ref_pecl_mode),
    .analog_supply_quiet_enable (analog_supply_quiet_enable),
    .clock_supply_quiet_enable  (clock_supply_quiet_enable),
    .alignment_delay_select     (alignment_delay_select),
    .alignment_fine_zoom        (alignment_fine_zoom),
    .full_scale_adjust          (full_scale_adjust)
  );

  // ----------------------------------------------------------------------
  // clock and hang guard
  // ----------------------------------------------------------------------
  // 50 ns period
  always #25 core_clk = ~core_clk;

  // the whole run needs well under a thousand cycles
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      errors++;
      report_and_stop();
    end
  end

  // ----------------------------------------------------------------------
  // helper tasks
  // ----------------------------------------------------------------------
  // one compare, counted
  task automatic chk(input logic [23:0] got, input logic [23:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      errors++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one byte write, strobe held for a single edge
  task automatic wr(input clock_range_pkg::reg_addr_t a,
                    input clock_range_pkg::reg_byte_t d);
    @(posedge core_clk);
    #5;
    wr_en    = 1'b1;
    reg_addr = a;
    wr_data  = d;
    @(posedge core_clk);
    #5;
    wr_en    = 1'b0;
  endtask : wr

  // one byte read; answer is due on the edge that takes the request
  task automatic rd(input clock_range_pkg::reg_addr_t a,
                    input clock_range_pkg::reg_byte_t exp);
    @(posedge core_clk);
    #5;
    rd_en    = 1'b1;
    reg_addr = a;
    @(posedge core_clk);
    #5;
    rd_en    = 1'b0;
    chk({23'h0, rd_valid}, 24'h00_0001);
    chk({16'h0, rd_data}, {16'h0, exp});
  endtask : rd

  // control outputs follow a write by two edges
  task automatic settle();
    repeat (2) @(posedge core_clk);
    #5;
  endtask : settle

  // closing report and verdict
  task automatic report_and_stop();
    $display("errors=%0d n_compared=%0d", errors, n_compared);
    if (errors == 0 && n_compared > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : report_and_stop

  // ----------------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------------
  initial
  begin
    core_clk          = 1'b0;
    arst_n            = 1'b0;
    wr_en             = 1'b0;
    rd_en             = 1'b0;
    reg_addr          = '0;
    wr_data           = '0;
    edge_pos_raw      = '0;
    alignment_ref_raw = 1'b0;
    errors            = 0;
    n_compared        = 0;
    cycles            = 0;
    fs_codes[0]       = 16'h2000;
    fs_codes[1]       = 16'hffff;
    repeat (16) @(posedge core_clk);
    #5;
    arst_n = 1'b1;
    // reset values at the pins and through the register port
    chk({8'h0, full_scale_adjust}, 24'h00_a000);
    chk({20'h0, sample_clock_pecl_mode, alignment_ref_pecl_mode,
         analog_supply_quiet_enable, clock_supply_quiet_enable}, 24'h0);
    rd(`ADDR_INPUT_MODE, 8'h00);
    rd(`ADDR_SUPPLY_NOISE, 8'h10);
    rd(`ADDR_DELAY_CTRL, 8'h80);
    rd(`ADDR_EDGE_POS_B0, 8'h00);
    rd(`ADDR_FULL_SCALE_B0, 8'h00);
    rd(`ADDR_FULL_SCALE_B1, 8'ha0);
    // each input mode bit alone drives its own control
    for (i = 0; i < 3; i++)
    begin
      wr(`ADDR_INPUT_MODE, 8'h01 << i);
      settle();
      // reference pin is low, so the invert bit alone raises the output
      chk({21'h0, sample_clock_pecl_mode, alignment_ref_pecl_mode,
           alignment_ref_aligned},
          24'h00_0004 >> (2 - i));
      rd(`ADDR_INPUT_MODE, 8'h01 << i);
    end
    // reference polarity, with and without inversion
    wr(`ADDR_INPUT_MODE, 8'h00);
    alignment_ref_raw = 1'b1;
    repeat (8) @(posedge core_clk);
    #5;
    chk({23'h0, alignment_ref_aligned}, 24'h00_0001);
    wr(`ADDR_INPUT_MODE, 8'h01);
    repeat (8) @(posedge core_clk);
    #5;
    chk({23'h0, alignment_ref_aligned}, 24'h00_0000);
    // supply quiet enables, reserved default kept in bit 4
    wr(`ADDR_SUPPLY_NOISE, 8'h14);
    settle();
    chk({22'h0, analog_supply_quiet_enable, clock_supply_quiet_enable},
        24'h00_0002);
    wr(`ADDR_SUPPLY_NOISE, 8'h11);
    settle();
    chk({22'h0, analog_supply_quiet_enable, clock_supply_quiet_enable},
        24'h00_0001);
    rd(`ADDR_SUPPLY_NOISE, 8'h11);
    // delay select and zoom
    wr(`ADDR_DELAY_CTRL, 8'h9a);
    settle();
    chk({19'h0, alignment_fine_zoom, alignment_delay_select},
        24'h00_001a);
    // edge position: live, read-only, reads leave it alone
    edge_pos_raw = 24'h12_3456;
    repeat (8) @(posedge core_clk);
    wr(`ADDR_EDGE_POS_B0, 8'hff);
    wr(`ADDR_EDGE_POS_B2, 8'h00);
    for (i = 0; i < 2; i++)
    begin
      rd(`ADDR_EDGE_POS_B0, 8'h56);
      rd(`ADDR_EDGE_POS_B1, 8'h34);
      rd(`ADDR_EDGE_POS_B2, 8'h12);
    end
    // delay picked from the position just read, bit 7 kept at default
    wr(`ADDR_DELAY_CTRL, 8'h86);
    settle();
    chk({20'h0, alignment_delay_select}, 24'h00_0006);
    // full-scale range at both ends of the recommended span
    for (i = 0; i < 2; i++)
    begin
      wr(`ADDR_FULL_SCALE_B0, fs_codes[i][7:0]);
      wr(`ADDR_FULL_SCALE_B1, fs_codes[i][15:8]);
      settle();
      chk({8'h0, full_scale_adjust}, {8'h0, fs_codes[i]});
      rd(`ADDR_FULL_SCALE_B1, fs_codes[i][15:8]);
    end
    // unmapped place: write ignored, read answers zero
    wr(15'h0040, 8'h5a);
    rd(15'h0040, 8'h00);
    report_and_stop();
  end
endmodule : testbench
